// [shared/asel_pkg.sv]
package asel_pkg;
    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [7:0] SPAN_CFG_ADDR   = 8'h14;
    localparam logic [7:0] ALARM_STAT_ADDR = 8'h20;
    localparam logic [7:0] OUT_CTL_ADDR    = 8'h30;
    localparam logic [7:0] IRQ_STAT_ADDR   = 8'h34;
    localparam logic [7:0] IRQ_EN_ADDR     = 8'h38;
    localparam logic [7:0] IRQ_CLR_ADDR    = 8'h3c;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int REF_OFF_BIT     = 6;
    localparam int SPAN_LSB        = 0;
    localparam int SPAN_W          = 4;
    localparam int SUP_LOW_ACT     = 15;
    localparam int SUP_HIGH_ACT    = 14;
    localparam int IN_LOW_ACT      = 11;
    localparam int IN_HIGH_ACT     = 10;
    localparam int SUP_LOW_LAT     = 7;
    localparam int SUP_HIGH_LAT    = 6;
    localparam int IN_LOW_LAT      = 5;
    localparam int IN_HIGH_LAT     = 4;
    localparam int ANY_LAT_BIT     = 0;
    localparam int SPAN_IN_FRM_BIT = 8;
    localparam int IRQ_W           = 4;
    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [3:0] SPAN_RST    = 4'h0;
    localparam logic       REF_OFF_RST = 1'b0;
    localparam logic [3:0] ALARM_RST   = 4'h0;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam int         POR_CYCLES  = 4;
endpackage

// [shared/asel_alarm_if.sv]
`timescale 1ns/1ns
interface asel_alarm_if;
    logic [3:0] act;   // present comparisons: suplo, suphi, inlo, inhi
    logic [3:0] lat;   // latched flags, same order
    logic       valid; // one conversion result
    logic       clr;   // status register read
    modport tracker (input act, input valid, input clr, output lat);
    modport owner   (output act, output valid, output clr, input lat);
endinterface

// [hdl/asel_alarm_latch.sv]
`timescale 1ns/1ns
module asel_alarm_latch (
    input  wire logic          sys_clk, // clock
    input  wire logic          rst,     // app reset
    asel_alarm_if.tracker      al       // alarm flags
);
    logic [3:0] lat_q;

    // set wins over the read clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            lat_q <= asel_pkg::ALARM_RST;
        end else begin
            lat_q <= (al.clr ? 4'h0 : lat_q) | (al.valid ? al.act : 4'h0);
        end
    end

    assign al.lat = lat_q;
endmodule

// [hdl/asel_regs.sv]
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
// Functional notes
// - span register at bytes 14h to 17h
// - reserved span bits read zero
// - bit 6 disables onchip reference, reset 0
// - codes 0-4 select bipolar spans
// - codes 8-11 select unipolar spans
// - span code cleared only at power-on
// - alarm register at 20h, read-only, reset 0
// - bits 15,14 live supply alarms
// - bits 11,10 live input alarms
// - bits 7,6 latched supply alarms
// - bits 5,4 latched input alarms
// - bit 0 ORs latched alarms
// - reserved alarm bits read zero
// - frame carries span code when enabled
module asel_regs (
    input  wire logic        sys_clk,       // 50 MHz clock
    input  wire logic        rst,           // app reset, sync high
    input  wire logic        por,           // power-on reset, sync high
    input  wire logic [7:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // byte strobes
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [7:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read valid
    input  wire logic        s_axi_rready,  // read ready
    input  wire logic [3:0]  alarmRaw,      // comparator levels, async
    input  wire logic        convDone,      // conversion finished
    input  wire logic [15:0] convData,      // conversion result
    output logic [19:0]      frameData,     // output frame
    output logic             frameValid,    // frame strobe
    output logic [3:0]       spanCode,      // range code to front end
    output logic             spanBipolar,   // bipolar range selected
    output logic             onchipRefOff,  // reference disabled
    output logic             irq            // level interrupt
);
    // ************************************************************
    // input synchroniser, 3 stages
    // ************************************************************
    logic [3:0] syncA_q;
    logic [3:0] syncB_q;
    logic [3:0] syncC_q;
    logic [3:0] alarmLive_q;

    always_ff @(posedge sys_clk) begin
        syncA_q <= alarmRaw;
        syncB_q <= syncA_q;
        syncC_q <= syncB_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            alarmLive_q <= asel_pkg::ALARM_RST;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (syncB_q[i] == syncC_q[i]) begin
                    alarmLive_q[i] <= syncC_q[i];
                end
            end
        end
    end

    // ************************************************************
    // register state
    // ************************************************************
    logic [3:0]  span_q;
    logic        refOff_q;
    logic        spanInFrm_q;
    logic [3:0]  act_q;
    logic [3:0]  irqSt_q;
    logic [3:0]  irqEn_q;
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        awHave_q;
    logic        wHave_q;
    logic [31:0] rdMux;
    logic        rdHit;
    logic        statRead;

    asel_alarm_if alIf ();

    asel_alarm_latch u_latch (
        .sys_clk (sys_clk),
        .rst     (rst || por),
        .al      (alIf.tracker)
    );

    assign alIf.act   = alarmLive_q;
    assign alIf.valid = convDone;
    assign alIf.clr   = statRead;

    // ************************************************************
    // write channel
    // ************************************************************
    assign wrEn = awHave_q && wHave_q && !s_axi_bvalid;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            awHave_q      <= 1'b0;
            awAddr_q      <= 8'h00;
        end else begin
            s_axi_awready <= !awHave_q && !s_axi_awready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end else if (wrEn) begin
                awHave_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_wready <= 1'b0;
            wHave_q      <= 1'b0;
            wData_q      <= 32'h0000_0000;
            wStrb_q      <= 4'h0;
        end else begin
            s_axi_wready <= !wHave_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end else if (wrEn) begin
                wHave_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= asel_pkg::RESP_OKAY;
        end else if (wrEn) begin
            s_axi_bvalid <= 1'b1;
            case (awAddr_q[7:2])
                asel_pkg::SPAN_CFG_ADDR[7:2],
                asel_pkg::ALARM_STAT_ADDR[7:2],
                asel_pkg::OUT_CTL_ADDR[7:2],
                asel_pkg::IRQ_STAT_ADDR[7:2],
                asel_pkg::IRQ_EN_ADDR[7:2],
                asel_pkg::IRQ_CLR_ADDR[7:2]: s_axi_bresp <= asel_pkg::RESP_OKAY;
                default:                     s_axi_bresp <= asel_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // span code survives app reset; only power-on clears it
    always_ff @(posedge sys_clk) begin
        if (por) begin
            span_q <= asel_pkg::SPAN_RST;
        end else if (wrEn && awAddr_q[7:2] == asel_pkg::SPAN_CFG_ADDR[7:2] && wStrb_q[0]) begin
            span_q <= wData_q[asel_pkg::SPAN_LSB +: asel_pkg::SPAN_W];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || por) begin
            refOff_q    <= asel_pkg::REF_OFF_RST;
            spanInFrm_q <= 1'b0;
            irqEn_q     <= 4'h0;
        end else if (wrEn) begin
            if (awAddr_q[7:2] == asel_pkg::SPAN_CFG_ADDR[7:2] && wStrb_q[0]) begin
                refOff_q <= wData_q[asel_pkg::REF_OFF_BIT];
            end
            if (awAddr_q[7:2] == asel_pkg::OUT_CTL_ADDR[7:2] && wStrb_q[1]) begin
                spanInFrm_q <= wData_q[asel_pkg::SPAN_IN_FRM_BIT];
            end
            if (awAddr_q[7:2] == asel_pkg::IRQ_EN_ADDR[7:2] && wStrb_q[0]) begin
                irqEn_q <= wData_q[asel_pkg::IRQ_W-1:0];
            end
        end
    end

    // ************************************************************
    // live flags and interrupts
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst || por) begin
            act_q <= asel_pkg::ALARM_RST;
        end else if (convDone) begin
            act_q <= alarmLive_q;
        end
    end

    logic       clrHit;
    logic [3:0] clrMask;
    assign clrHit  = wrEn && awAddr_q[7:2] == asel_pkg::IRQ_CLR_ADDR[7:2] && wStrb_q[0];
    assign clrMask = clrHit ? wData_q[asel_pkg::IRQ_W-1:0] : 4'h0;

    always_ff @(posedge sys_clk) begin
        if (rst || por) begin
            irqSt_q <= 4'h0;
        end else begin
            irqSt_q <= (irqSt_q & ~clrMask) | (convDone ? alarmLive_q : 4'h0);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || por) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqSt_q & irqEn_q);
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    assign rdEn     = s_axi_arvalid && s_axi_arready;
    assign statRead = rdEn && s_axi_araddr[7:2] == asel_pkg::ALARM_STAT_ADDR[7:2];

    always_comb begin
        rdMux = 32'h0000_0000;
        rdHit = 1'b1;
        case (s_axi_araddr[7:2])
            asel_pkg::SPAN_CFG_ADDR[7:2]: begin
                rdMux[asel_pkg::SPAN_LSB +: asel_pkg::SPAN_W] = span_q;
                rdMux[asel_pkg::REF_OFF_BIT] = refOff_q;
            end
            asel_pkg::ALARM_STAT_ADDR[7:2]: begin
                rdMux[asel_pkg::SUP_LOW_ACT]  = act_q[3];
                rdMux[asel_pkg::SUP_HIGH_ACT] = act_q[2];
                rdMux[asel_pkg::IN_LOW_ACT]   = act_q[1];
                rdMux[asel_pkg::IN_HIGH_ACT]  = act_q[0];
                rdMux[asel_pkg::SUP_LOW_LAT]  = alIf.lat[3];
                rdMux[asel_pkg::SUP_HIGH_LAT] = alIf.lat[2];
                rdMux[asel_pkg::IN_LOW_LAT]   = alIf.lat[1];
                rdMux[asel_pkg::IN_HIGH_LAT]  = alIf.lat[0];
                rdMux[asel_pkg::ANY_LAT_BIT]  = |alIf.lat;
            end
            asel_pkg::OUT_CTL_ADDR[7:2]:  rdMux[asel_pkg::SPAN_IN_FRM_BIT] = spanInFrm_q;
            asel_pkg::IRQ_STAT_ADDR[7:2]: rdMux[asel_pkg::IRQ_W-1:0] = irqSt_q;
            asel_pkg::IRQ_EN_ADDR[7:2]:   rdMux[asel_pkg::IRQ_W-1:0] = irqEn_q;
            asel_pkg::IRQ_CLR_ADDR[7:2]:  rdMux = 32'h0000_0000;
            default:                      rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= asel_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (rdEn) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rdMux;
                s_axi_rresp   <= rdHit ? asel_pkg::RESP_OKAY : asel_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // outputs to converter
    // ************************************************************
    always_ff @(posedge sys_clk) begin
        if (rst || por) begin
            frameData    <= 20'h00000;
            frameValid   <= 1'b0;
            onchipRefOff <= asel_pkg::REF_OFF_RST;
        end else begin
            frameValid   <= convDone;
            if (convDone) begin
                frameData <= spanInFrm_q ? {convData, span_q} : {4'h0, convData};
            end
            onchipRefOff <= refOff_q;
        end
    end

    // span outputs keep the front end steady over app reset
    always_ff @(posedge sys_clk) begin
        if (por) begin
            spanCode    <= asel_pkg::SPAN_RST;
            spanBipolar <= !asel_pkg::SPAN_RST[3];
        end else begin
            spanCode    <= span_q;
            spanBipolar <= !span_q[3];
        end
    end
endmodule

// [verification/asel_regs_sva.sv]
`timescale 1ns/1ns
module asel_regs_sva (
    input wire logic        sys_clk,       // clock
    input wire logic        rst,           // app reset
    input wire logic        por,           // power-on reset
    input wire logic [7:0]  s_axi_araddr,  // read addr
    input wire logic        s_axi_arvalid, // ar valid
    input wire logic        s_axi_arready, // ar ready
    input wire logic [31:0] s_axi_rdata,   // read data
    input wire logic [1:0]  s_axi_rresp,   // read resp
    input wire logic        s_axi_rvalid,  // r valid
    input wire logic        s_axi_rready,  // r ready
    input wire logic        convDone,      // conversion done
    input wire logic [15:0] convData,      // result
    input wire logic [19:0] frameData,     // frame
    input wire logic        frameValid,    // frame strobe
    input wire logic [3:0]  spanCode,      // span code
    input wire logic        spanBipolar,   // bipolar
    input wire logic        onchipRefOff   // ref off
);
    logic [7:0] lastAr_q;
    logic       spanRd;
    logic       almRd;
    always_ff @(posedge sys_clk) begin
        if (s_axi_arvalid && s_axi_arready) lastAr_q <= s_axi_araddr;
    end
    assign spanRd = s_axi_rvalid && lastAr_q == asel_pkg::SPAN_CFG_ADDR;
    assign almRd  = s_axi_rvalid && lastAr_q == asel_pkg::ALARM_STAT_ADDR;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst || por);
    // ************************************************************
    // properties
    // ************************************************************
    property p_bipolar;
        !$past(rst) && !$past(por) |-> spanBipolar == !spanCode[3];
    endproperty
    a_bipolar: assert property (p_bipolar) else $error("span polarity wrong");
    property p_span_rd;
        spanRd |-> s_axi_rdata[3:0] == spanCode && s_axi_rdata[6] == onchipRefOff;
    endproperty
    a_span_rd: assert property (p_span_rd) else $error("span readback wrong");
    property p_span_rsv;
        spanRd |-> s_axi_rdata[31:7] == 25'h0 && s_axi_rdata[5:4] == 2'h0;
    endproperty
    a_span_rsv: assert property (p_span_rsv) else $error("span reserved set");
    property p_alm_rsv;
        almRd |-> {s_axi_rdata[31:16], s_axi_rdata[13:12], s_axi_rdata[9:8],
                   s_axi_rdata[3:1]} == 23'h0;
    endproperty
    a_alm_rsv: assert property (p_alm_rsv) else $error("alarm reserved set");
    property p_alm_or;
        almRd |-> s_axi_rdata[0] == |s_axi_rdata[7:4];
    endproperty
    a_alm_or: assert property (p_alm_or) else $error("summary bit wrong");
    property p_frame_lat;
        convDone |=> frameValid;
    endproperty
    a_frame_lat: assert property (p_frame_lat) else $error("frame missing");
    property p_frame;
        frameValid |-> frameData == {4'h0, $past(convData)}
                    || frameData == {$past(convData), spanCode};
    endproperty
    a_frame: assert property (p_frame) else $error("frame content wrong");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {8'h14, 8'h20, 8'h30,
            8'h34, 8'h38, 8'h3c}) |=> s_axi_rvalid && s_axi_rresp == 2'b10 && s_axi_rdata == 0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_app_rst;
        $fell(rst) |-> !onchipRefOff;
    endproperty
    a_app_rst: assert property (p_app_rst) else $error("ref off kept over reset");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
endmodule

// [verification/adc_range_alarm_regs_test.sv]
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin mismatches++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module adc_range_alarm_regs_test;
    logic sys_clk = 0, rst = 1, por = 1, convDone = 0;
    logic awv = 0, wv = 0, bRdy = 0, arv = 0, rRdy = 0;
    logic [7:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, rnd;
    logic [3:0] alarmRaw = 0, span = 0, spanCode;
    logic [15:0] convData = 0;
    logic [1:0] bresp, rresp;
    logic [19:0] frameData;
    logic awr, wr_, bv, arr, rv, frameValid, spanBipolar, onchipRefOff, irq, inFrame = 0;
    int mismatches = 0, n_tests = 0, seed = 32'hc3af;
    logic [1:0] bQ[$];
    logic [33:0] rQ[$];
    logic [19:0] fQ[$];
    asel_regs uut (.sys_clk(sys_clk), .rst(rst), .por(por), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(bRdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rRdy),
        .alarmRaw(alarmRaw), .convDone(convDone), .convData(convData),
        .frameData(frameData), .frameValid(frameValid), .spanCode(spanCode),
        .spanBipolar(spanBipolar), .onchipRefOff(onchipRefOff), .irq(irq));
    initial forever #10 sys_clk = ~sys_clk;
    // ************************************************************
    // result watcher
    // ************************************************************
    always @(posedge sys_clk) begin
        if (bv && bRdy) `CHK("bresp", bQ.pop_front(), bresp)
        if (rv && rRdy) `CHK("read", rQ.pop_front(), {rresp, rdat})
        if (frameValid) `CHK("frame", fQ.pop_front(), frameData)
    end
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ************************************************************
    // bus tasks
    // ************************************************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        bQ.push_back(er);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bRdy <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge sys_clk);
            if (awr) awv <= 1'b0;
            if (wr_) wv <= 1'b0;
            if (bv) break;
        end
        bRdy <= 1'b0;
        if (k == 40) begin mismatches++; tally_and_finish; end
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] ex);
        int k;
        rQ.push_back(ex);
        ara <= a;
        arv <= 1'b1;
        rRdy <= 1'b1;
        for (k = 0; k < 40; k++) begin
            @(posedge sys_clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rRdy <= 1'b0;
        if (k == 40) begin mismatches++; tally_and_finish; end
    endtask
    task automatic conv(input logic [3:0] raw);
        alarmRaw <= raw;
        repeat (6) @(posedge sys_clk);
        rnd = $random(seed);
        fQ.push_back(inFrame ? {rnd[15:0], span} : {4'h0, rnd[15:0]});
        convData <= rnd[15:0];
        convDone <= 1'b1;
        @(posedge sys_clk);
        convDone <= 1'b0;
        @(posedge sys_clk);
    endtask
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        por <= 1'b0;
        @(posedge sys_clk);
        rd(8'h14, 34'h0);
        wr(8'h20, 32'hffff_ffff, 2'b00);
        rd(8'h20, 34'h0);
        for (int i = 0; i < 9; i++) begin
            span = (i < 5) ? i[3:0] : 4'h3 + i[3:0];
            rnd = $random(seed);
            wr(8'h14, {rnd[31:4], span}, 2'b00);
            rd(8'h14, {27'h0, rnd[6], 2'b00, span});
        end
        span = 4'ha;
        wr(8'h14, 32'hffff_ff4a, 2'b00);
        rd(8'h14, 34'h4a);
        rst <= 1'b1;
        @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        `CHK("span out", 4'ha, spanCode)
        `CHK("bipolar", 1'b0, spanBipolar)
        `CHK("ref off", 1'b0, onchipRefOff)
        rd(8'h14, 34'h0a);
        rd(8'h18, {2'b10, 32'h0});
        wr(8'h18, $random(seed), 2'b10);
        rd(8'h3c, 34'h0);
        wr(8'h38, 32'h0, 2'b00);
        conv(4'b1001);
        `CHK("irq", 1'b0, irq)
        rd(8'h20, 34'h8491);
        rd(8'h20, 34'h8400);
        wr(8'h38, 32'hf, 2'b00);
        repeat (3) @(posedge sys_clk);
        `CHK("irq", 1'b1, irq)
        rd(8'h34, 34'h9);
        conv(4'b0000);
        wr(8'h3c, 32'hf, 2'b00);
        repeat (3) @(posedge sys_clk);
        `CHK("irq", 1'b0, irq)
        conv(4'b0110);
        conv(4'b0000);
        rd(8'h20, 34'h61);
        rd(8'h20, 34'h0);
        wr(8'h30, 32'h100, 2'b00);
        rd(8'h30, 34'h100);
        inFrame = 1'b1;
        conv(4'b0000);
        conv(4'b1000);
        por <= 1'b1;
        @(posedge sys_clk);
        por <= 1'b0;
        @(posedge sys_clk);
        `CHK("span out", 4'h0, spanCode)
        rd(8'h14, 34'h0);
        rd(8'h20, 34'h0);
        repeat (3) @(posedge sys_clk);
        `CHK("pending", 0, bQ.size() + rQ.size() + fQ.size())
        tally_and_finish;
    end
endmodule
bind asel_regs asel_regs_sva u_sva (.sys_clk(sys_clk), .rst(rst), .por(por),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .convDone(convDone), .convData(convData),
    .frameData(frameData), .frameValid(frameValid), .spanCode(spanCode),
    .spanBipolar(spanBipolar), .onchipRefOff(onchipRefOff));
